// *** logic/ltcp_cfg.svh ***
// Constants for the legacy track CV programming interpreter.
`ifndef LTCP_CFG_SVH
`define LTCP_CFG_SVH
`define LTCP_CLK_PERIOD_NS 8
`define LTCP_TICK_NS 1000000
`define LTCP_TICK_CYC \
    ((`LTCP_TICK_NS + `LTCP_CLK_PERIOD_NS - 1) / `LTCP_CLK_PERIOD_NS)
`define LTCP_BLINK_PERIOD_MS 10'h3e8
`define LTCP_BLINK_ON_MS 10'h1f4
`define LTCP_ACK_ON_MS 10'h064
`define LTCP_ACK_OFF_MS 10'h096
`define LTCP_ZERO_CODE 7'h50
`define LTCP_SHORT_MAX 7'h4f
`define LTCP_MODE_CV 10'h050
`define LTCP_ONES_MAX 7'h09
`define LTCP_VHI_MAX 7'h19
`define LTCP_CV_MAX 10'h31f
`define LTCP_VAL_MAX 10'h0ff
`define LTCP_ACK_WRITE 3'h1
`define LTCP_ACK_CV 3'h2
`define LTCP_ACK_CV_LO 3'h3
`define LTCP_ACK_VAL_HI 3'h4
`endif

// *** logic/ltcp_pkg.sv ***
// Types shared by the legacy track CV programming interpreter.
`default_nettype none
package ltcp_pkg;
    typedef enum logic [3:0] {
        LTCP_ST_OFF       = 4'h0,
        LTCP_ST_SELECTED  = 4'h1,
        LTCP_ST_STOPPED   = 4'h2,
        LTCP_ST_HOLD      = 4'h3,
        LTCP_ST_RELEASE   = 4'h4,
        LTCP_ST_SH_CV     = 4'h5,
        LTCP_ST_SH_VAL    = 4'h6,
        LTCP_ST_LG_CV_HI  = 4'h7,
        LTCP_ST_LG_CV_LO  = 4'h8,
        LTCP_ST_LG_VAL_HI = 4'h9,
        LTCP_ST_LG_VAL_LO = 4'ha
    } ltcp_state_e;

    typedef struct packed {
        logic       legacy;
        logic [6:0] addr;
        logic       dir_chg;
        logic       stop;
        logic       start;
    } ltcp_cmd_s;

    typedef struct packed {
        logic [9:0] cv;
        logic [7:0] data;
    } ltcp_wr_s;
endpackage
`default_nettype wire

// *** logic/ltcp_prog.sv ***
// Legacy track format CV programming interpreter with headlight feedback.
`include "ltcp_cfg.svh"
`default_nettype none

// Notes on behaviour
// - Legacy track format is detected automatically.
// - Idle programming mode blinks headlight once per second.
// - Programming always begins in short mode.
// - Short mode takes variables 1 to 79 and values 0 to 79.
// - Long mode builds variable and value from two digits.
// - Writing 80 to variable 80 selects long mode.
// - Direction change commits; variable acknowledged by two flashes.
// - Code 80 stands for the value zero.
// - Final step writes, flashes once; power loss ends.
// - Long first step: variable tens, two flashes.
// - Long second step: variable ones, three flashes.
// - Long third step: value tens, four flashes.
// - Long fourth step: value ones completes the value.
// - Value byte uses plain binary weighting.
module ltcp_prog #(
    parameter int TICK_CYC = `LTCP_TICK_CYC
) (
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    input wire logic TRK_POWER_I,
    input wire logic [6:0] LOCO_ADDR_I,
    input wire logic CMD_VALID_I,
    input wire ltcp_pkg::ltcp_cmd_s CMD_I,
    input wire logic LIGHT_NORMAL_I,
    output logic HEADLIGHT_O,
    output logic PROG_ACTIVE_O,
    output logic LONG_MODE_O,
    output logic FMT_LEGACY_O,
    output logic WR_VALID_O,
    output ltcp_pkg::ltcp_wr_s WR_O
);

    // ************************************************************
    // Helper arithmetic
    // ************************************************************

    // Maps a received code to its number; 80 means zero.
    function automatic logic [6:0] ltcp_code(input logic [6:0] raw);
        ltcp_code = (raw == `LTCP_ZERO_CODE) ? 7'h00 : raw;
    endfunction

    // Scales a tens-and-hundreds digit pair to its full weight.
    function automatic logic [9:0] ltcp_x10(input logic [6:0] v);
        ltcp_x10 = 10'({3'h0, v} * 10'h00a);
    endfunction

    // ************************************************************
    // Command interpretation
    // ************************************************************

    ltcp_pkg::ltcp_state_e st_q, st_d;
    logic fmt_q, fmt_d;
    logic dir_q, dir_d;
    logic long_q, long_d;
    logic [9:0] cv_q, cv_d;
    logic [9:0] vhi_q, vhi_d;
    logic wr_q, wr_d;
    ltcp_pkg::ltcp_wr_s wrd_q, wrd_d;
    logic [2:0] ack_set;
    logic legacy_frm;
    logic own_frm;
    logic commit;
    logic [6:0] num;
    logic [9:0] total;

    // Commits are taken on the leading edge of a direction change so
    // that a station repeating the same frame cannot commit twice.
    assign legacy_frm = CMD_VALID_I && CMD_I.legacy;
    assign own_frm = legacy_frm && (CMD_I.addr == LOCO_ADDR_I);
    assign commit = legacy_frm && CMD_I.dir_chg && !dir_q;
    assign num = ltcp_code(CMD_I.addr);

    // Next state of the interpreter; power loss clears the session.
    always_comb begin
        st_d = st_q;
        fmt_d = fmt_q;
        dir_d = dir_q;
        long_d = long_q;
        cv_d = cv_q;
        vhi_d = vhi_q;
        wr_d = 1'b0;
        wrd_d = wrd_q;
        ack_set = 3'h0;
        total = 10'h000;
        if (CMD_VALID_I) begin
            fmt_d = CMD_I.legacy;
        end
        if (legacy_frm) begin
            dir_d = CMD_I.dir_chg;
        end
        case (st_q)
            ltcp_pkg::LTCP_ST_OFF: begin
                if (own_frm) begin
                    st_d = ltcp_pkg::LTCP_ST_SELECTED;
                end
            end
            ltcp_pkg::LTCP_ST_SELECTED: begin
                if (legacy_frm && CMD_I.stop) begin
                    st_d = ltcp_pkg::LTCP_ST_STOPPED;
                end else if (legacy_frm && !own_frm) begin
                    st_d = ltcp_pkg::LTCP_ST_OFF;
                end
            end
            ltcp_pkg::LTCP_ST_STOPPED: begin
                if (own_frm && CMD_I.dir_chg) begin
                    st_d = ltcp_pkg::LTCP_ST_HOLD;
                end else if (legacy_frm && CMD_I.start) begin
                    st_d = ltcp_pkg::LTCP_ST_OFF;
                end
            end
            ltcp_pkg::LTCP_ST_HOLD: begin
                if (legacy_frm && CMD_I.start) begin
                    st_d = ltcp_pkg::LTCP_ST_RELEASE;
                end else if (own_frm && !CMD_I.dir_chg) begin
                    st_d = ltcp_pkg::LTCP_ST_STOPPED;
                end
            end
            ltcp_pkg::LTCP_ST_RELEASE: begin
                if (own_frm && !CMD_I.dir_chg) begin
                    st_d = ltcp_pkg::LTCP_ST_SH_CV;
                    long_d = 1'b0;
                end
            end
            ltcp_pkg::LTCP_ST_SH_CV: begin
                // Raw 80 is kept so that it can arm the mode switch.
                if (commit && CMD_I.addr != 7'h00
                    && CMD_I.addr <= `LTCP_ZERO_CODE) begin
                    cv_d = {3'h0, CMD_I.addr};
                    st_d = ltcp_pkg::LTCP_ST_SH_VAL;
                    ack_set = `LTCP_ACK_CV;
                end
            end
            ltcp_pkg::LTCP_ST_SH_VAL: begin
                if (commit && cv_q == `LTCP_MODE_CV) begin
                    if (CMD_I.addr == `LTCP_ZERO_CODE) begin
                        long_d = 1'b1;
                        st_d = ltcp_pkg::LTCP_ST_LG_CV_HI;
                        ack_set = `LTCP_ACK_WRITE;
                    end
                end else if (commit && CMD_I.addr != 7'h00
                             && CMD_I.addr <= `LTCP_ZERO_CODE) begin
                    wr_d = 1'b1;
                    wrd_d.cv = cv_q;
                    wrd_d.data = {1'b0, num};
                    st_d = ltcp_pkg::LTCP_ST_SH_CV;
                    ack_set = `LTCP_ACK_WRITE;
                end
            end
            ltcp_pkg::LTCP_ST_LG_CV_HI: begin
                if (commit && CMD_I.addr != 7'h00
                    && CMD_I.addr <= `LTCP_ZERO_CODE) begin
                    cv_d = ltcp_x10(num);
                    st_d = ltcp_pkg::LTCP_ST_LG_CV_LO;
                    ack_set = `LTCP_ACK_CV;
                end
            end
            ltcp_pkg::LTCP_ST_LG_CV_LO: begin
                total = cv_q + {3'h0, num};
                // A variable number of zero is refused.
                if (commit && CMD_I.addr != 7'h00
                    && num <= `LTCP_ONES_MAX && total != 10'h000
                    && total <= `LTCP_CV_MAX) begin
                    cv_d = total;
                    st_d = ltcp_pkg::LTCP_ST_LG_VAL_HI;
                    ack_set = `LTCP_ACK_CV_LO;
                end
            end
            ltcp_pkg::LTCP_ST_LG_VAL_HI: begin
                if (commit && CMD_I.addr != 7'h00
                    && num <= `LTCP_VHI_MAX) begin
                    vhi_d = ltcp_x10(num);
                    st_d = ltcp_pkg::LTCP_ST_LG_VAL_LO;
                    ack_set = `LTCP_ACK_VAL_HI;
                end
            end
            ltcp_pkg::LTCP_ST_LG_VAL_LO: begin
                total = vhi_q + {3'h0, num};
                if (commit && CMD_I.addr != 7'h00
                    && num <= `LTCP_ONES_MAX
                    && total <= `LTCP_VAL_MAX) begin
                    wr_d = 1'b1;
                    wrd_d.cv = cv_q;
                    wrd_d.data = total[7:0];
                    st_d = ltcp_pkg::LTCP_ST_LG_CV_HI;
                    ack_set = `LTCP_ACK_WRITE;
                end
            end
            default: begin
                st_d = ltcp_pkg::LTCP_ST_OFF;
            end
        endcase
        // Without track power the whole session is forgotten.
        if (!TRK_POWER_I) begin
            st_d = ltcp_pkg::LTCP_ST_OFF;
            long_d = 1'b0;
            wr_d = 1'b0;
            // A write cut short by power loss must not disturb the held word.
            wrd_d = wrd_q;
            ack_set = 3'h0;
        end
    end

    // Registers of the interpreter.
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            st_q <= ltcp_pkg::LTCP_ST_OFF;
            fmt_q <= 1'b0;
            dir_q <= 1'b0;
            long_q <= 1'b0;
            cv_q <= 10'h000;
            vhi_q <= 10'h000;
            wr_q <= 1'b0;
            wrd_q <= '0;
        end else begin
            st_q <= st_d;
            fmt_q <= fmt_d;
            dir_q <= dir_d;
            long_q <= long_d;
            cv_q <= cv_d;
            vhi_q <= vhi_d;
            wr_q <= wr_d;
            wrd_q <= wrd_d;
        end
    end

    // ************************************************************
    // Headlight signalling
    // ************************************************************

    logic prog;
    logic ms_tick;
    logic [16:0] tick_q, tick_d;
    logic [9:0] ms_q, ms_d;
    logic [2:0] ack_q, ack_d;
    logic on_q, on_d;
    logic lamp_q, lamp_d;

    assign prog = (st_q >= ltcp_pkg::LTCP_ST_SH_CV);
    assign ms_tick = (tick_q == 17'(TICK_CYC - 1));

    // A millisecond divider paces the flashes; acknowledge bursts take
    // priority over the idle blink, which restarts once they finish.
    always_comb begin
        tick_d = ms_tick ? 17'h00000 : tick_q + 17'h00001;
        ms_d = ms_q;
        ack_d = ack_q;
        on_d = on_q;
        if (ack_set != 3'h0) begin
            tick_d = 17'h00000;
            ms_d = 10'h000;
            ack_d = ack_set;
            on_d = 1'b1;
        end else if (ms_tick) begin
            ms_d = ms_q + 10'h001;
            if (ack_q != 3'h0) begin
                if (on_q && ms_d >= `LTCP_ACK_ON_MS) begin
                    on_d = 1'b0;
                    ms_d = 10'h000;
                end else if (!on_q && ms_d >= `LTCP_ACK_OFF_MS) begin
                    ack_d = ack_q - 3'h1;
                    on_d = (ack_q != 3'h1);
                    ms_d = 10'h000;
                end
            end else if (ms_d >= `LTCP_BLINK_PERIOD_MS) begin
                ms_d = 10'h000;
            end
        end
        if (!prog) begin
            ack_d = 3'h0;
            on_d = 1'b0;
        end
        if (!prog) begin
            lamp_d = LIGHT_NORMAL_I;
        end else if (ack_q != 3'h0) begin
            lamp_d = on_q;
        end else begin
            lamp_d = (ms_q < `LTCP_BLINK_ON_MS);
        end
    end

    // Registers of the headlight sequencer.
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            tick_q <= 17'h00000;
            ms_q <= 10'h000;
            ack_q <= 3'h0;
            on_q <= 1'b0;
            lamp_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            ms_q <= ms_d;
            ack_q <= ack_d;
            on_q <= on_d;
            lamp_q <= lamp_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // All outputs except PROG_ACTIVE_O, which is decoded from st_q, come straight from flip-flops.
    assign HEADLIGHT_O = lamp_q;
    assign PROG_ACTIVE_O = prog;
    assign LONG_MODE_O = long_q;
    assign FMT_LEGACY_O = fmt_q;
    assign WR_VALID_O = wr_q;
    assign WR_O = wrd_q;

endmodule

`default_nettype wire

// *** test/ltcp_prog_asserts.sv ***
// Port checks for the legacy track programming interpreter.
`default_nettype none
module ltcp_chk #(
    parameter int TICK_CYC = 10
) (
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    input wire logic TRK_POWER_I,
    input wire logic CMD_VALID_I,
    input wire ltcp_pkg::ltcp_cmd_s CMD_I,
    input wire logic LIGHT_NORMAL_I,
    input wire logic HEADLIGHT_O,
    input wire logic PROG_ACTIVE_O,
    input wire logic LONG_MODE_O,
    input wire logic FMT_LEGACY_O,
    input wire logic WR_VALID_O,
    input wire ltcp_pkg::ltcp_wr_s WR_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);

    // Format, write pulse and write source relations.
    property p_fmt;
        CMD_VALID_I |=> FMT_LEGACY_O == $past(CMD_I.legacy);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format flag");
    property p_pulse;
        WR_VALID_O |=> !WR_VALID_O;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");
    // The reset guard avoids a false hit when reset clears the bus.
    property p_hold;
        !$past(SYS_RST_I) && $changed(WR_O) |-> WR_VALID_O;
    endproperty
    a_hold: assert property (p_hold) else $error("bus moved");
    property p_commit;
        WR_VALID_O |-> $past(CMD_VALID_I && CMD_I.legacy && CMD_I.dir_chg);
    endproperty
    a_commit: assert property (p_commit) else $error("no commit");
    // Ranges of the written variable and value.
    property p_short;
        WR_VALID_O && !LONG_MODE_O |-> WR_O.cv inside {[1:79]} &&
            WR_O.data <= 8'h4f;
    endproperty
    a_short: assert property (p_short) else $error("short range");
    property p_range;
        WR_VALID_O |-> WR_O.cv inside {[1:799]};
    endproperty
    a_range: assert property (p_range) else $error("cv range");
    // Power loss and the lamp outside programming.
    property p_pwr;
        !TRK_POWER_I |=> !PROG_ACTIVE_O && !WR_VALID_O;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power loss");
    property p_lamp;
        !$past(SYS_RST_I) && !PROG_ACTIVE_O && !$past(PROG_ACTIVE_O) |->
            HEADLIGHT_O == $past(LIGHT_NORMAL_I);
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp level");
    c_prog: cover property ($rose(PROG_ACTIVE_O));
    c_long: cover property ($rose(LONG_MODE_O));
    c_write: cover property (WR_VALID_O);
endmodule
bind ltcp_prog ltcp_chk #(.TICK_CYC(TICK_CYC)) chk_u (.CLK_SYS_I, .SYS_RST_I,
    .TRK_POWER_I, .CMD_VALID_I, .CMD_I, .LIGHT_NORMAL_I, .HEADLIGHT_O,
    .PROG_ACTIVE_O, .LONG_MODE_O, .FMT_LEGACY_O, .WR_VALID_O, .WR_O);
`default_nettype wire

// *** test/ltcp_station.sv ***
// Command station model that sends legacy track frames.
`default_nettype none
module ltcp_station (
    input wire logic CLK_SYS_I,
    output logic CMD_VALID_O,
    output ltcp_pkg::ltcp_cmd_s CMD_O
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        CMD_VALID_O = 1'b0;
        CMD_O = '0;
    end
    // One frame lasts one cycle; afterwards the word is scrambled so a
    // stale frame can never pass for a fresh one.
    task automatic frame(input logic lg, input logic [6:0] a,
        input logic d, input logic sp, input logic st);
        @(negedge CLK_SYS_I);
        CMD_VALID_O = 1'b1;
        CMD_O = '{lg, a, d, sp, st};
        @(negedge CLK_SYS_I);
        CMD_VALID_O = 1'b0;
        CMD_O = ~CMD_O;
    endtask
    // Select, stop, hold the regulator, start, release.
    task automatic enter(input logic [6:0] a);
        frame(1'b1, a, 1'b0, 1'b0, 1'b0);
        frame(1'b1, a, 1'b0, 1'b1, 1'b0);
        frame(1'b1, a, 1'b1, 1'b0, 1'b0);
        frame(1'b1, a, 1'b1, 1'b0, 1'b1);
        frame(1'b1, a, 1'b0, 1'b0, 1'b0);
    endtask
    // An address, a pause of gap plus one cycles, then the brief direction change.
    task automatic step(input int v, input int gap);
        logic [6:0] c;
        c = (v == 0) ? 7'h50 : 7'(v);
        frame(1'b1, c, 1'b0, 1'b0, 1'b0);
        repeat (gap) @(negedge CLK_SYS_I);
        frame(1'b1, c, 1'b1, 1'b0, 1'b0);
    endtask
endmodule
`default_nettype wire

// *** test/legacy_track_cv_programming_test.sv ***
// Self-checking bench for the legacy track programming interpreter.
`default_nettype none
module legacy_track_cv_programming_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 10;
    localparam logic [6:0] LOCO = 7'h03;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pwr = 1'b1;
    logic lnorm = 1'b1;
    logic cmd_valid, head, prog, lmode, fmt, wr_v;
    ltcp_pkg::ltcp_cmd_s cmd;
    ltcp_pkg::ltcp_wr_s wr;
    ltcp_pkg::ltcp_wr_s last_wr = '0;
    int wr_cnt = 0;
    int miscompares = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    ltcp_prog #(.TICK_CYC(TK)) dut_u (.CLK_SYS_I(clk), .SYS_RST_I(rst),
        .TRK_POWER_I(pwr), .LOCO_ADDR_I(LOCO), .CMD_VALID_I(cmd_valid),
        .CMD_I(cmd), .LIGHT_NORMAL_I(lnorm), .HEADLIGHT_O(head),
        .PROG_ACTIVE_O(prog), .LONG_MODE_O(lmode), .FMT_LEGACY_O(fmt),
        .WR_VALID_O(wr_v), .WR_O(wr));
    ltcp_station stn_u (.CLK_SYS_I(clk), .CMD_VALID_O(cmd_valid),
        .CMD_O(cmd));
    // Record every write so scenarios can judge count and content.
    always @(posedge clk) begin
        if (wr_v === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            last_wr <= wr;
        end
    end
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Lamp time is judged in 100 ms units, so the phase of the idle blink
    // at the window edges cannot tip the result.
    task automatic lamp_chk(input int win_ms, input int exp_ms);
        int on;
        on = 0;
        repeat (win_ms * TK) begin
            @(posedge clk);
            #1 on += int'(head === 1'b1);
        end
        check(18'((on + 50 * TK) / (100 * TK)), 18'(exp_ms / 100));
    endtask
    task automatic t_format;
        stn_u.frame(1'b0, LOCO, 1'b0, 1'b0, 1'b0);
        check(18'(fmt), 18'h0);
        stn_u.frame(1'b1, 7'h11, 1'b0, 1'b0, 1'b0);
        check(18'(fmt), 18'h1);
    endtask
    task automatic t_entry;
        stn_u.enter(LOCO);
        check(18'({prog, lmode}), 18'h2);
        lamp_chk(1000, 500);
    endtask
    // Out-of-range variable first, then a zero and a boundary write.
    task automatic t_short;
        stn_u.step(81, 0);
        stn_u.step(5, 3);
        lamp_chk(502, 200);
        stn_u.step(0, 0);
        lamp_chk(252, 100);
        check(last_wr, 18'h00500);
        stn_u.step(79, 0);
        lamp_chk(502, 200);
        stn_u.step(79, 1);
        lamp_chk(252, 100);
        check(last_wr, 18'h04f4f);
        check(18'(wr_cnt), 18'h2);
    endtask
    // Switch to long mode, then write 253 to variable 799.
    task automatic t_long;
        stn_u.step(80, 0);
        lamp_chk(502, 200);
        stn_u.step(0, 0);
        lamp_chk(252, 100);
        check(18'({lmode, 5'(wr_cnt)}), 18'h22);
        stn_u.step(79, 0);
        lamp_chk(502, 200);
        stn_u.step(9, 0);
        lamp_chk(752, 300);
        stn_u.step(26, 0);
        stn_u.step(25, 0);
        lamp_chk(1002, 400);
        stn_u.step(3, 0);
        lamp_chk(252, 100);
        check(last_wr, 18'h31ffd);
    endtask
    task automatic t_power;
        @(negedge clk);
        pwr = 1'b0;
        lnorm = 1'b0;
        repeat (3) @(negedge clk);
        check(18'({prog, head}), 18'h0);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Main sequence, started after six reset cycles.
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        check(18'({head, prog, lmode, wr_v}), 18'h0);
        t_format();
        t_entry();
        t_short();
        t_long();
        t_power();
        give_verdict();
    end
    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
